// ==== rtl/cbt_engine.sv ====
// CSMA backoff and single-packet transmit engine with APB registers.
`timescale 1ns/1ps
module cbt_engine (
  // Clock and reset
  input  wire  logic                  ref_clk,
  input  wire  logic                  nrst,
  // APB slave
  input  wire  logic                  psel,
  input  wire  logic                  penable,
  input  wire  logic                  pwrite,
  input  wire  logic [11:0]           paddr,
  input  wire  logic [31:0]           pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // Radio side
  input  wire  cbt_pkg::cbt_radio_in_type radio,
  output logic                        rx_power_on,
  output logic                        rx_suspend,
  output logic                        tx_byte_valid,
  output logic [7:0]                  tx_byte,
  output logic                        foreground_done_irq,
  output logic                        chain_next
);
  import cbt_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    cbt_state_type    st;
    logic             is_tx;
    logic             stop_req;
    logic             abort_req;
    logic             tx_started;
    cbt_csma_cfg_type ccfg;
    cbt_csma_var_type cvar;
    cbt_tx_cfg_type   tcfg;
    logic [2:0]       cw;
    logic [15:0]      lfsr;
    logic [15:0]      wait_periods;
    logic [16:0]      cyc;
    logic [15:0]      bytes_left;
    logic [1:0]       phase;
    logic [15:0]      crc;
    logic [15:0]      status;
    logic [1:0]       result;
    logic [31:0]      last_cca_time;
    logic [31:0]      tstamp;
    logic [31:0]      tx_start_offset;
    logic             rx_on;
    logic             rx_susp;
    logic             tv;
    logic [7:0]       tb;
    logic             irq;
    logic             chain;
    logic             rdy;
    logic [31:0]      rdata;
    logic             err;
  } cbt_regs_type;

  cbt_regs_type r;
  cbt_regs_type next_r;

  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    lfsr_step = {v[14:0], ^(v & LFSR_TAPS)};
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 0; i < 8; i++) begin
      x = (x[0] ^ d[i]) ? ((x >> 1) ^ 16'h8408) : (x >> 1);
    end
    crc_step = x;
  endfunction

  logic [15:0] draw_mask;
  logic        bo_end;
  logic        busy_act;
  logic        power_ok;
  logic        apb_acc;

  always_comb begin
    next_r = r;
    draw_mask = 16'((17'h1 << r.cvar.backoff_exponent) - 17'h1);
    busy_act = radio.frame_rx | radio.ack_tx;
    bo_end = (r.cyc == 17'(BACKOFF_CYC - 1));
    power_ok = (r.wait_periods > 16'h1) ||
               (r.cyc < 17'(BACKOFF_CYC - CCA_LEAD_CYC));
    apb_acc = psel & penable & ~r.rdy;
    next_r.irq = 1'b0;
    next_r.chain = 1'b0;
    next_r.tv = 1'b0;
    next_r.rdy = 1'b0;
    next_r.err = 1'b0;

    // ----------------------------------------------------------------
    // APB slave, one wait state
    // ----------------------------------------------------------------
    if (apb_acc) begin
      next_r.rdy = 1'b1;
      next_r.rdata = 32'h0;
      if (pwrite) begin
        if (paddr == ADDR_CTRL) begin
          if (pwdata[CTRL_STOP] && r.st != S_IDLE) begin
            next_r.stop_req = 1'b1;
          end
          if (pwdata[CTRL_ABORT] && r.st != S_IDLE) begin
            next_r.abort_req = 1'b1;
          end
          if (r.st == S_IDLE && (pwdata[CTRL_START_CSMA] | pwdata[CTRL_START_TX])) begin
            next_r.st = S_WAIT;
            next_r.is_tx = pwdata[CTRL_START_TX];
            next_r.stop_req = 1'b0;
            next_r.abort_req = 1'b0;
            next_r.tx_started = 1'b0;
            next_r.status = ST_IDLE;
          end
        end else if (paddr == ADDR_CSMA_CFG) begin
          next_r.ccfg = pwdata[28:0];
        end else if (paddr == ADDR_CSMA_VAR) begin
          next_r.cvar = pwdata[22:0];
        end else if (paddr == ADDR_TX_CFG) begin
          next_r.tcfg = pwdata[17:0];
        end else if (paddr == ADDR_TX_OFS) begin
          next_r.tx_start_offset = pwdata;
        end else if (paddr != ADDR_TX_LEN) begin
          next_r.err = 1'b1;
        end
      end else begin
        if (paddr == ADDR_CTRL) begin
          next_r.rdata = {25'h0, r.st};
        end else if (paddr == ADDR_CSMA_CFG) begin
          next_r.rdata = {3'h0, r.ccfg};
        end else if (paddr == ADDR_CSMA_VAR) begin
          next_r.rdata = {9'h0, r.cvar};
        end else if (paddr == ADDR_TX_CFG) begin
          next_r.rdata = {14'h0, r.tcfg};
        end else if (paddr == ADDR_TX_LEN) begin
          next_r.rdata = {16'h0, r.bytes_left};
        end else if (paddr == ADDR_STATUS) begin
          next_r.rdata = {14'h0, r.result, r.status};
        end else if (paddr == ADDR_LAST_CCA) begin
          next_r.rdata = r.last_cca_time;
        end else if (paddr == ADDR_TSTAMP) begin
          next_r.rdata = r.tstamp;
        end else if (paddr == ADDR_TX_OFS) begin
          next_r.rdata = r.tx_start_offset;
        end else begin
          next_r.err = 1'b1;
        end
      end
    end

    // ----------------------------------------------------------------
    // Operation sequencer
    // ----------------------------------------------------------------
    case (r.st)
      S_IDLE: begin
        next_r.rx_on = 1'b1;
        next_r.rx_susp = 1'b0;
      end
      S_WAIT: begin
        if (r.abort_req) begin
          next_r.st = S_DONE;
          next_r.status = ST_ABORT;
          next_r.result = RES_ABORT;
        end else if (r.stop_req) begin
          next_r.st = S_DONE;
          next_r.status = ST_STOPPED;
          next_r.result = RES_FALSE;
        end else if (!r.is_tx && radio.bg_ended) begin
          next_r.st = S_DONE;
          next_r.status = ST_BGEND;
          next_r.result = RES_ABORT;
        end else if (!r.is_tx && (r.ccfg.initial_contention_window == 3'h0 ||
                                  r.ccfg.max_be > MAX_BE_LIMIT)) begin
          next_r.st = S_DONE;
          next_r.status = ST_BAD_PAR;
          next_r.result = RES_ABORT;
        end else if (radio.begin_condition) begin
          next_r.cyc = 17'h0;
          if (r.is_tx) begin
            next_r.rx_susp = 1'b1;
            if (!radio.synth_on) begin
              next_r.st = S_DONE;
              next_r.status = ST_NO_SYNTH;
              next_r.result = RES_ABORT;
            end else begin
              next_r.st = r.tcfg.phy_header_supplied ? S_TXRUN : S_TXHDR;
              next_r.tx_started = 1'b1;
              next_r.tstamp = radio.radio_timer + r.tx_start_offset;
              next_r.bytes_left = {r.tcfg.payload_length_high,
                                   r.tcfg.payload_length};
              next_r.phase = r.tcfg.phy_header_supplied ? 2'h1 : 2'h0;
              next_r.crc = 16'h0;
            end
          end else begin
            next_r.cw = r.ccfg.initial_contention_window;
            if (r.ccfg.seed_state_field != 16'h0) begin
              next_r.lfsr = r.ccfg.seed_state_field;
            end else if (radio.radio_timer[15:0] != 16'h0) begin
              next_r.lfsr = radio.radio_timer[15:0];
            end else begin
              next_r.lfsr = LFSR_SUBST;
            end
            if (r.cvar.remaining_backoff_periods != 16'h0) begin
              next_r.wait_periods = r.cvar.remaining_backoff_periods;
            end else begin
              next_r.wait_periods = next_r.lfsr &
                                    draw_mask;
            end
            next_r.st = (next_r.wait_periods == 16'h0) ? S_CCA : S_BACK;
          end
        end
      end
      S_BACK, S_CCA: begin
        next_r.cyc = bo_end ? 17'h0 : r.cyc + 17'h1;
        next_r.lfsr = lfsr_step(r.lfsr);
        if (r.st == S_BACK && r.ccfg.rx_off_sel != 2'h0 && power_ok) begin
          case (r.ccfg.rx_off_sel)
            2'h1: next_r.rx_on = busy_act | (r.rx_on & radio.frame_rx);
            2'h2: next_r.rx_on = r.rx_on & busy_act;
            default: next_r.rx_on = 1'b0;
          endcase
        end else begin
          next_r.rx_on = 1'b1;
        end
        if (r.abort_req) begin
          next_r.st = S_DONE;
          next_r.status = ST_ABORT;
          next_r.result = RES_ABORT;
        end else if (radio.bg_ended) begin
          next_r.st = S_DONE;
          next_r.status = ST_BGEND;
          next_r.result = RES_ABORT;
        end else if (r.stop_req || radio.finish_condition) begin
          next_r.st = S_DONE;
          next_r.status = r.stop_req ? ST_STOPPED : ST_TIMEOUT;
          next_r.result = RES_FALSE;
          next_r.cvar.remaining_backoff_periods = r.wait_periods;
        end else if (r.st == S_BACK && bo_end) begin
          if (r.wait_periods == 16'h0) begin
            next_r.st = S_CCA;
          end else begin
            next_r.wait_periods = r.wait_periods - 16'h1;
            if (r.wait_periods == 16'h1) begin
              next_r.st = S_CCA;
            end
          end
        end else if (r.st == S_CCA) begin
          next_r.last_cca_time = radio.radio_timer;
          if (radio.cca == CCA_IDLE) begin
            next_r.cw = r.cw - 3'h1;
            if (r.cw == 3'h1) begin
              next_r.st = S_DONE;
              next_r.status = ST_OK;
              next_r.result = RES_TRUE;
            end else begin
              next_r.st = S_BACK;
              next_r.wait_periods = 16'h1;
            end
          end else if (radio.cca == CCA_BUSY) begin
            next_r.cw = r.ccfg.initial_contention_window;
            next_r.cvar.backoff_attempt_count = r.cvar.backoff_attempt_count + 3'h1;
            next_r.cvar.backoff_exponent = (r.cvar.backoff_exponent + 4'h1 > r.ccfg.max_be) ?
              r.ccfg.max_be : r.cvar.backoff_exponent + 4'h1;
            if (r.cvar.backoff_attempt_count >= r.ccfg.max_backoffs) begin
              next_r.st = S_DONE;
              next_r.status = ST_BUSY;
              next_r.result = RES_FALSE;
            end else begin
              next_r.st = S_BACK;
              next_r.wait_periods = r.lfsr & draw_mask;
            end
          end else begin
            next_r.st = S_BACK;
            next_r.wait_periods = 16'h1;
          end
          next_r.cyc = 17'h0;
        end
      end
      S_TXHDR, S_TXRUN: begin
        next_r.cyc = (r.cyc == 17'(BYTE_CYC - 1)) ? 17'h0 : r.cyc + 17'h1;
        if (r.abort_req) begin
          next_r.st = S_DONE;
          next_r.status = ST_ABORT;
          next_r.result = RES_ABORT;
        end else if (r.cyc == 17'h0) begin
          next_r.tv = 1'b1;
          if (r.st == S_TXHDR) begin
            next_r.tb = r.bytes_left[7:0] + (r.tcfg.crc_supplied ? 8'h0 : 8'h2);
            next_r.st = S_TXRUN;
          end else if (r.phase != 2'h2 && r.bytes_left != 16'h0) begin
            next_r.tb = r.bytes_left[7:0];
            next_r.crc = crc_step(r.crc, r.bytes_left[7:0]);
            next_r.bytes_left = r.bytes_left - 16'h1;
          end else if (!r.tcfg.crc_supplied && r.phase != 2'h3) begin
            next_r.tb = (r.phase == 2'h2) ? r.crc[15:8] : r.crc[7:0];
            next_r.phase = (r.phase == 2'h2) ? 2'h3 : 2'h2;
          end else begin
            next_r.tv = 1'b0;
            next_r.st = S_DONE;
            next_r.last_cca_time = radio.radio_timer;
            next_r.status = r.stop_req ? ST_STOPPED : ST_OK;
            next_r.result = r.stop_req ? RES_FALSE : RES_TRUE;
          end
        end
      end
      S_DONE: begin
        next_r.irq = 1'b1;
        next_r.chain = (r.result == RES_TRUE);
        next_r.rx_susp = 1'b0;
        next_r.rx_on = 1'b1;
        if (!r.is_tx) begin
          next_r.ccfg.seed_state_field = r.lfsr;
          if (r.status != ST_STOPPED && r.status != ST_TIMEOUT) begin
            next_r.cvar.remaining_backoff_periods = 16'h0;
          end
        end
        next_r.st = S_IDLE;
      end
      default: begin
        next_r.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.st <= S_IDLE;
      r.rx_on <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign pready = r.rdy;
  assign prdata = r.rdata;
  assign pslverr = r.err;
  assign rx_power_on = r.rx_on;
  assign rx_suspend = r.rx_susp;
  assign tx_byte_valid = r.tv;
  assign tx_byte = r.tb;
  assign foreground_done_irq = r.irq;
  assign chain_next = r.chain;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_mode0_on;
    @(posedge ref_clk) disable iff (!nrst)
      (r.st == S_BACK && r.ccfg.rx_off_sel == 2'h0) |=> rx_power_on;
  endproperty
  a_mode0_on: assert property (p_mode0_on) else $error("receiver off in mode 0");

  property p_done_irq;
    @(posedge ref_clk) disable iff (!nrst)
      (r.st == S_DONE) |=> foreground_done_irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done without interrupt");

  property p_chain;
    @(posedge ref_clk) disable iff (!nrst)
      chain_next |-> (r.result == RES_TRUE) && foreground_done_irq;
  endproperty
  a_chain: assert property (p_chain) else $error("chain without true result");

  property p_no_synth;
    @(posedge ref_clk) disable iff (!nrst)
      (r.st == S_WAIT && r.is_tx && radio.begin_condition && !radio.synth_on &&
       !r.abort_req && !r.stop_req) |=> (r.status == ST_NO_SYNTH) ##1 foreground_done_irq;
  endproperty
  a_no_synth: assert property (p_no_synth) else $error("missing synthesizer error");

  property p_tstamp;
    @(posedge ref_clk) disable iff (!nrst)
      (r.st == S_WAIT && (next_r.st == S_TXHDR || next_r.st == S_TXRUN)) |=>
        (r.tstamp == $past(radio.radio_timer) + $past(r.tx_start_offset));
  endproperty
  a_tstamp: assert property (p_tstamp) else $error("timestamp not captured");

  property p_stop_wait;
    @(posedge ref_clk) disable iff (!nrst)
      (r.st == S_WAIT && r.stop_req && !r.abort_req) |=> !tx_byte_valid [*2];
  endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("sent after early stop");

  property p_abort_tx;
    @(posedge ref_clk) disable iff (!nrst)
      ((r.st == S_TXRUN) && r.abort_req) |=> (r.st == S_DONE) && (r.result == RES_ABORT);
  endproperty
  a_abort_tx: assert property (p_abort_tx) else $error("abort not immediate");

  property p_mode3_off;
    @(posedge ref_clk) disable iff (!nrst)
      (r.st == S_BACK && r.ccfg.rx_off_sel == 2'h3 && power_ok && !bo_end &&
       next_r.st == S_BACK) |=> !rx_power_on;
  endproperty
  a_mode3_off: assert property (p_mode3_off) else $error("receiver on in mode 3");

endmodule

// ==== rtl/cbt_pkg.sv ====
// Constants, register map and carrier types of the CSMA backoff and transmit engine.
// Function
// - LFSR backoff numbers, seeded, state written back.
// - Zero seed uses timer bits, else constant.
// - Mode 0 keeps receiver on.
// - Mode 1 holds radio only during activity.
// - Mode 2 finishes activity, then off.
// - Mode 3 switches radio off immediately.
// - Power down only with time; restart early.
// - Busy channel reloads window, counts, raises exponent.
// - CSMA end status and result pairs.
// - Every end writes status, raises done.
// - Result selects chain or idle.
// - Event 1 time recorded at end.
// - Transmit waits begin condition, then suspends receiver.
// - No synthesizer ends transmit with error.
// - Length adds 256 times high field.
// - Insert header and CRC unless supplied.
// - Abort ends transmission at once.
// - Stop before start sends nothing; else finishes.
// - Timestamp is timer value triggering modem.
// - Transmit end status and result pairs.
package cbt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_CSMA_CFG = 12'h004;
  localparam logic [11:0] ADDR_CSMA_VAR = 12'h008;
  localparam logic [11:0] ADDR_TX_CFG   = 12'h00c;
  localparam logic [11:0] ADDR_TX_LEN   = 12'h010;
  localparam logic [11:0] ADDR_STATUS   = 12'h014;
  localparam logic [11:0] ADDR_LAST_CCA = 12'h018;
  localparam logic [11:0] ADDR_TSTAMP   = 12'h01c;
  localparam logic [11:0] ADDR_TX_OFS   = 12'h020;

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  localparam int CTRL_START_CSMA = 0;
  localparam int CTRL_START_TX   = 1;
  localparam int CTRL_STOP       = 2;
  localparam int CTRL_ABORT      = 3;

  // ----------------------------------------------------------------
  // Status codes and results
  // ----------------------------------------------------------------
  localparam logic [15:0] ST_IDLE     = 16'h0000;
  localparam logic [15:0] ST_OK       = 16'h2400;
  localparam logic [15:0] ST_BUSY     = 16'h2401;
  localparam logic [15:0] ST_STOPPED  = 16'h2402;
  localparam logic [15:0] ST_TIMEOUT  = 16'h2404;
  localparam logic [15:0] ST_ABORT    = 16'h2405;
  localparam logic [15:0] ST_BGEND    = 16'h2408;
  localparam logic [15:0] ST_BAD_PAR  = 16'h2801;
  localparam logic [15:0] ST_NO_SYNTH = 16'h2802;

  localparam logic [1:0] RES_TRUE  = 2'h1;
  localparam logic [1:0] RES_FALSE = 2'h2;
  localparam logic [1:0] RES_ABORT = 2'h3;

  // ----------------------------------------------------------------
  // Timing and constants
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ          = 250;
  localparam int          BACKOFF_US       = 320;
  localparam int          BACKOFF_CYC      = BACKOFF_US * CLK_MHZ;
  localparam int          CCA_LEAD_US      = 20;
  localparam int          CCA_LEAD_CYC     = CCA_LEAD_US * CLK_MHZ;
  localparam int          BYTE_US          = 32;
  localparam int          BYTE_CYC         = BYTE_US * CLK_MHZ;
  localparam logic [15:0] LFSR_TAPS        = 16'hb400;
  localparam logic [15:0] LFSR_SUBST       = 16'hace1;
  localparam logic [3:0]  MAX_BE_LIMIT     = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_WAIT  = 7'b0000010,
    S_BACK  = 7'b0000100,
    S_CCA   = 7'b0001000,
    S_TXHDR = 7'b0010000,
    S_TXRUN = 7'b0100000,
    S_DONE  = 7'b1000000
  } cbt_state_type;

  typedef struct packed {
    logic [1:0] rx_off_sel;
    logic       slotted_select;
    logic [2:0] initial_contention_window;
    logic [3:0] max_be;
    logic [2:0] max_backoffs;
    logic [15:0] seed_state_field;
  } cbt_csma_cfg_type;

  typedef struct packed {
    logic [2:0]  backoff_attempt_count;
    logic [3:0]  backoff_exponent;
    logic [15:0] remaining_backoff_periods;
  } cbt_csma_var_type;

  typedef struct packed {
    logic       phy_header_supplied;
    logic       crc_supplied;
    logic [7:0] payload_length_high;
    logic [7:0] payload_length;
  } cbt_tx_cfg_type;

  typedef struct packed {
    logic        frame_rx;
    logic        ack_tx;
    logic        synth_on;
    logic        bg_active;
    logic        bg_ended;
    logic [1:0]  cca;
    logic        begin_condition;
    logic        finish_condition;
    logic [31:0] radio_timer;
  } cbt_radio_in_type;

  localparam logic [1:0] CCA_IDLE    = 2'h0;
  localparam logic [1:0] CCA_BUSY    = 2'h1;
  localparam logic [1:0] CCA_INVALID = 2'h2;

endpackage

// ==== test/cbt_host.sv ====
// Host model that issues register transfers on the APB port.
`timescale 1ns/1ps
module cbt_host (
  // Clock and answer
  input  wire logic        ref_clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  // Setup, then access held until pready is sampled high.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ==== test/csma_backoff_and_tx_ops_tb.sv ====
// Self-checking bench for the CSMA backoff and transmit engine.
`timescale 1ns/1ps
module csma_backoff_and_tx_ops_tb;
  import cbt_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} cbt_row_type;
  logic             ref_clk, nrst, psel, penable, pwrite, pready, pslverr, er;
  logic             rx_power_on, rx_suspend, tx_byte_valid, foreground_done_irq, chain_next;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [7:0]       tx_byte, first;
  cbt_radio_in_type radio;
  int               fails, n_tests, nbytes, ndone, nchain, noff;
  cbt_row_type      rows [6];

  cbt_host host_u (.ref_clk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
                   .pwdata);
  cbt_engine dut_u (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
                    .prdata, .pslverr, .radio, .rx_power_on, .rx_suspend, .tx_byte_valid,
                    .tx_byte, .foreground_done_irq, .chain_next);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask

  // Counts bytes, done pulses and chain pulses of the running operation.
  always @(posedge ref_clk) begin
    radio.radio_timer <= radio.radio_timer + 32'h1;
    if (tx_byte_valid === 1'b1) begin
      if (nbytes == 0) first = tx_byte;
      chk("suspend", 32'h1, {31'h0, rx_suspend});
      nbytes++;
    end
    ndone += (foreground_done_irq === 1'b1);
    nchain += (chain_next === 1'b1);
    noff += (rx_power_on === 1'b0);
  end

  task automatic op(input logic [31:0] c, input logic [31:0] c2, input logic late,
                    input logic [31:0] st, input int nb, input int nc);
    nbytes = 0;
    ndone  = 0;
    nchain = 0;
    noff   = 0;
    host_u.xfer(1'b1, ADDR_CTRL, c, rd, er);
    if (c2 != 0 && !late) host_u.xfer(1'b1, ADDR_CTRL, c2, rd, er);
    radio.begin_condition <= 1'b1;
    for (int i = 0; i < 20000 && late && nbytes == 0; i++) @(posedge ref_clk);
    if (late) host_u.xfer(1'b1, ADDR_CTRL, c2, rd, er);
    for (int i = 0; i < 90000 && ndone == 0; i++) @(posedge ref_clk);
    radio.begin_condition <= 1'b0;
    host_u.xfer(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk("status", st, rd);
    chk("bytes", 32'(nb), 32'(nbytes));
    chk("done", 32'h1, 32'(ndone));
    chk("chain", 32'(nc), 32'(nchain));
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #600000;
    fails++;
    end_of_test;
  end

  initial begin
    nrst = 1'b0;
    radio = '0;
    radio.synth_on = 1'b1;
    fails = 0;
    n_tests = 0;
    nbytes = 0;
    ndone = 0;
    nchain = 0;
    rows = '{'{ADDR_CSMA_VAR, 32'h0071_0005, 32'h0071_0005, 1'b0},
             '{ADDR_TX_OFS, 32'h0000_0010, 32'h0000_0010, 1'b0},
             '{ADDR_STATUS, 32'h0000_ffff, 32'h0, 1'b0},
             '{ADDR_TSTAMP, 32'h0000_ffff, 32'h0, 1'b0},
             '{12'h024, 32'h1, 32'h0, 1'b1},
             '{ADDR_TX_CFG, 32'h0000_0001, 32'h0000_0001, 1'b0}};
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    chk("rx_power_on", 32'h1, {31'h0, rx_power_on});
    foreach (rows[k]) begin
      host_u.xfer(1'b1, rows[k].a, rows[k].d, rd, er);
      host_u.xfer(1'b0, rows[k].a, 32'h0, rd, er);
      chk("slverr", {31'h0, rows[k].e}, {31'h0, er});
      if (!rows[k].e) chk("readback", rows[k].r, rd);
    end
    op(32'h2, 32'h0, 1'b0, {14'h0, RES_TRUE, ST_OK}, 4, 1);
    chk("header", 32'h3, {24'h0, first});
    host_u.xfer(1'b1, ADDR_TX_CFG, 32'h0003_0002, rd, er);
    op(32'h2, 32'h4, 1'b1, {14'h0, RES_FALSE, ST_STOPPED}, 2, 0);
    op(32'h2, 32'h8, 1'b1, {14'h0, RES_ABORT, ST_ABORT}, 1, 0);
    op(32'h2, 32'h4, 1'b0, {14'h0, RES_FALSE, ST_STOPPED}, 0, 0);
    radio.synth_on <= 1'b0;
    op(32'h2, 32'h0, 1'b0, {14'h0, RES_ABORT, ST_NO_SYNTH}, 0, 0);
    host_u.xfer(1'b1, ADDR_CSMA_CFG, 32'h0000_0001, rd, er);
    op(32'h1, 32'h0, 1'b0, {14'h0, RES_ABORT, ST_BAD_PAR}, 0, 0);
    host_u.xfer(1'b1, ADDR_CSMA_VAR, 32'h0, rd, er);
    host_u.xfer(1'b1, ADDR_CSMA_CFG, 32'h0080_0001, rd, er);
    radio.cca <= CCA_BUSY;
    op(32'h1, 32'h0, 1'b0, {14'h0, RES_FALSE, ST_BUSY}, 0, 0);
    radio.cca <= CCA_IDLE;
    host_u.xfer(1'b0, ADDR_CSMA_VAR, 32'h0, rd, er);
    chk("attempts", 32'h0010_0000, rd);
    host_u.xfer(1'b1, ADDR_CSMA_VAR, 32'h0, rd, er);
    op(32'h1, 32'h0, 1'b0, {14'h0, RES_TRUE, ST_OK}, 0, 1);
    chk("rx_power_on", 32'h1, {31'h0, rx_power_on});
    host_u.xfer(1'b1, ADDR_CSMA_VAR, 32'h1, rd, er);
    radio.finish_condition <= 1'b1;
    op(32'h1, 32'h0, 1'b0, {14'h0, RES_FALSE, ST_TIMEOUT}, 0, 0);
    radio.finish_condition <= 1'b0;
    chk("rx_on_mode0", 32'h0, 32'(noff));
    host_u.xfer(1'b0, ADDR_CSMA_VAR, 32'h0, rd, er);
    chk("remaining", 32'h1, rd);
    host_u.xfer(1'b1, ADDR_CSMA_CFG, 32'h1880_0001, rd, er);
    op(32'h1, 32'h8, 1'b1, {14'h0, RES_ABORT, ST_ABORT}, 0, 0);
    chk("rx_off_mode3", 32'h1, {31'h0, (noff > 0)});
    end_of_test;
  end
endmodule
